// File: utc_cfg.svh
// register map, field positions, reset values and timing counts
`ifndef UTC_CFG_SVH
`define UTC_CFG_SVH

// ==========================================================
// register byte offsets
`define UTC_OFS_TRANSCEIVER_SUSPEND_PD 12'h100
`define UTC_OFS_OBSERVE 12'h104
`define UTC_OFS_PULLUP 12'h108
`define UTC_OFS_TRC0 12'h10c
`define UTC_OFS_MODE 12'h110
`define UTC_OFS_IRQ_STAT 12'h118
`define UTC_OFS_IRQ_MASK 12'h11c

// ==========================================================
// field positions
`define UTC_BIT_TRANSCEIVER_SUSPEND 7
`define UTC_BIT_PDE 6
`define UTC_BIT_DPLUS_PULLUP_SEEN_SEEN 7
`define UTC_BIT_DPLUS_PULLDOWN_SEEN_SEEN 6
`define UTC_BIT_DMINUS_PULLDOWN_SEEN_SEEN 4
`define UTC_BIT_DEV_PULLUP 4
`define UTC_BIT_SOFT_RST 7
`define UTC_BIT_RESUME_EN 5
`define UTC_BIT_SYNC_SEEN 1
`define UTC_BIT_RESUME_INT 0
`define UTC_BIT_HOST_MODE 0
`define UTC_BIT_OTG_MODE 1
`define UTC_IRQ_RESUME 0
`define UTC_IRQ_SYNC 1
`define UTC_IRQ_RST_DONE 2

// ==========================================================
// reset values
`define UTC_RST_TRANSCEIVER_SUSPEND 1'b0
`define UTC_RST_PDE 1'b1
`define UTC_RST_DEV_PULLUP 1'b0
`define UTC_RST_RESUME_EN 1'b0
`define UTC_RST_MODE 2'h0
`define UTC_RST_IRQ 3'h0

// ==========================================================
// timing: soft reset lasts this many module clock cycles
`define UTC_SOFT_RST_CYCLES 2'h2

`endif

// File: utc_pkg.sv
// shared types of the transceiver control block
package utc_pkg;
    // one byte-wide register image
    typedef logic [7:0] utc_byte_t;
    // pending event set, one bit per event source
    typedef logic [2:0] utc_irq_t;
endpackage : utc_pkg

// File: utc_top.sv
// usb transceiver control: suspend, pulls, soft reset, async resume wakeup
//
// Summary of operation
// - suspend bit high puts the transceiver into suspend.
// - pulldown enable switches weak pulldowns on both D+ and D-.
// - reserved bits read zero and ignore writes.
// - observe bit 7 shows the live D+ pullup output.
// - observe bit 6 shows the D+ pulldown output.
// - observe bit 4 shows the D- pulldown output.
// - observe register is read-only, resets with both pulldowns shown set.
// - pullup control bit drives D+ pullup only in non-OTG device mode.
// - writing the soft reset bit resets the module, then bit self-clears.
// - soft reset bit reads zero; software waits two clocks after it.
// - resume enable lets bus resume raise an asynchronous wakeup event.
// - wakeup works only in device mode, never in host mode.
// - status bit 1 reads one once a synchronous interrupt is detected.
// - status bit 0 reads one when asynchronous resume raised an interrupt.
// - resume detection senses K-state on raw D+ and D- lines.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "utc_cfg.svh"

module utc_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // raw bus line levels and core event
    input wire logic dp_rx_i,
    input wire logic dm_rx_i,
    input wire logic sync_usb_int_i,
    // transceiver controls
    output logic transceiver_suspend_o,
    output logic dp_pulldown_o,
    output logic dm_pulldown_o,
    output logic dp_pullup_o,
    output logic module_soft_reset_o,
    // wakeup and interrupt
    output logic wakeup_o,
    output logic irq_o
);

    // ==========================================================
    // state
    logic weak_pulldown_enable;
    logic device_mode_dplus_pullup;
    logic resume_wakeup_enable;
    logic [1:0] mode_cfg;
    utc_pkg::utc_irq_t irq_stat;
    utc_pkg::utc_irq_t irq_mask;
    logic [1:0] rst_cnt;
    logic [1:0] sync_ff;
    logic [1:0] res_ff;
    logic res_seen_d;
    logic resume_int;
    logic resume_set;
    logic host_mode;
    logic otg_mode;
    logic rd_take;
    logic wr_fire;
    logic in_rst;
    logic mapped;
    logic [31:0] next_rdata;
    utc_pkg::utc_irq_t next_irq_stat;
    utc_pkg::utc_byte_t obs;
    utc_pkg::utc_byte_t trc0;

    // ==========================================================
    // apb strobes: data sampled in first access cycle, write lands with pready
    assign rd_take = psel_i && penable_i && !pready_o;
    assign wr_fire = psel_i && penable_i && pready_o && pwrite_i;
    assign in_rst = (rst_cnt != 2'h0);
    assign host_mode = mode_cfg[`UTC_BIT_HOST_MODE];
    assign otg_mode = mode_cfg[`UTC_BIT_OTG_MODE];

    // ==========================================================
    // async resume detector: K-state on raw lines sets flag without clock
    assign resume_set = dm_rx_i && !dp_rx_i && resume_wakeup_enable
                        && !host_mode;

    // resume flag: async set, cleared on clock when enable drops
    // a K-state that is still on the lines cannot set the flag again after a
    // clear, as the set path needs the enable on; software may drop it during K
    // the set path carries no clock at all, which is what lets the
    // wakeup leave while the module clock is gated
    always_ff @(posedge clk_i or posedge sys_rst_i or posedge resume_set) begin
        if (sys_rst_i) begin
            resume_int <= 1'b0;
        end else if (resume_set) begin
            resume_int <= 1'b1;
        end else if (!resume_wakeup_enable || in_rst) begin
            resume_int <= 1'b0;
        end
    end
    // wakeup leaves straight from the flag flop, so a gated clock is fine
    assign wakeup_o = resume_int;

    // ==========================================================
    // synchronisers for the async flag and the core interrupt line
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            res_ff <= 2'h0;
            sync_ff <= 2'h0;
            res_seen_d <= 1'b0;
        end else begin
            res_ff <= {res_ff[0], resume_int};
            sync_ff <= {sync_ff[0], sync_usb_int_i};
            res_seen_d <= res_ff[1];
        end
    end

    // ==========================================================
    // soft reset counter; holds the module in reset for two clocks
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_cnt <= 2'h0;
        end else if (wr_fire && paddr_i == `UTC_OFS_TRC0
                     && pwdata_i[`UTC_BIT_SOFT_RST]) begin
            rst_cnt <= `UTC_SOFT_RST_CYCLES;
        end else if (in_rst) begin
            rst_cnt <= rst_cnt - 2'h1;
        end
    end
    // soft reset output from its own flop; it follows the nonzero count
    // exactly, so other blocks never see a glitch from the count compare
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            module_soft_reset_o <= 1'b0;
        end else if (wr_fire && paddr_i == `UTC_OFS_TRC0
                     && pwdata_i[`UTC_BIT_SOFT_RST]) begin
            module_soft_reset_o <= 1'b1;
        end else if (rst_cnt == 2'h1) begin
            module_soft_reset_o <= 1'b0;
        end
    end

    // ==========================================================
    // suspend and pulldown control register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            transceiver_suspend_o <= `UTC_RST_TRANSCEIVER_SUSPEND;
            weak_pulldown_enable <= `UTC_RST_PDE;
        end else if (in_rst) begin
            transceiver_suspend_o <= `UTC_RST_TRANSCEIVER_SUSPEND;
            weak_pulldown_enable <= `UTC_RST_PDE;
        end else if (wr_fire && paddr_i == `UTC_OFS_TRANSCEIVER_SUSPEND_PD) begin
            transceiver_suspend_o <= pwdata_i[`UTC_BIT_TRANSCEIVER_SUSPEND];
            weak_pulldown_enable <= pwdata_i[`UTC_BIT_PDE];
        end
    end

    // pulldown outputs registered; one enable drives both lines
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dp_pulldown_o <= `UTC_RST_PDE;
            dm_pulldown_o <= `UTC_RST_PDE;
        end else begin
            dp_pulldown_o <= weak_pulldown_enable;
            dm_pulldown_o <= weak_pulldown_enable;
        end
    end

    // ==========================================================
    // pullup control, mode configuration and resume enable
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            device_mode_dplus_pullup <= `UTC_RST_DEV_PULLUP;
            resume_wakeup_enable <= `UTC_RST_RESUME_EN;
            mode_cfg <= `UTC_RST_MODE;
        end else if (in_rst) begin
            device_mode_dplus_pullup <= `UTC_RST_DEV_PULLUP;
            resume_wakeup_enable <= `UTC_RST_RESUME_EN;
            mode_cfg <= `UTC_RST_MODE;
        end else if (wr_fire) begin
            if (paddr_i == `UTC_OFS_PULLUP) begin
                device_mode_dplus_pullup <= pwdata_i[`UTC_BIT_DEV_PULLUP];
            end else if (paddr_i == `UTC_OFS_TRC0) begin
                resume_wakeup_enable <= pwdata_i[`UTC_BIT_RESUME_EN];
            end else if (paddr_i == `UTC_OFS_MODE) begin
                mode_cfg <= pwdata_i[1:0];
            end
        end
    end

    // pullup only in plain device mode; host or otg keeps it off
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dp_pullup_o <= 1'b0;
        end else begin
            dp_pullup_o <= device_mode_dplus_pullup && !host_mode && !otg_mode;
        end
    end

    // ==========================================================
    // interrupt status: set wins over clear-on-read
    always_comb begin
        next_irq_stat = irq_stat;
        if (rd_take && !pwrite_i && paddr_i == `UTC_OFS_IRQ_STAT) begin
            next_irq_stat = 3'h0;
        end
        if (res_ff[1] && !res_seen_d) begin
            next_irq_stat[`UTC_IRQ_RESUME] = 1'b1;
        end
        if (sync_ff[1]) begin
            next_irq_stat[`UTC_IRQ_SYNC] = 1'b1;
        end
        if (rst_cnt == 2'h1) begin
            next_irq_stat[`UTC_IRQ_RST_DONE] = 1'b1;
        end
    end

    // status and mask registers, plus the level interrupt output
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_stat <= `UTC_RST_IRQ;
            irq_mask <= `UTC_RST_IRQ;
            irq_o <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            if (wr_fire && paddr_i == `UTC_OFS_IRQ_MASK) begin
                irq_mask <= pwdata_i[2:0];
            end
            irq_o <= |(next_irq_stat & irq_mask);
        end
    end

    // ==========================================================
    // read images; reserved bits tie to zero
    assign obs = {dp_pullup_o, dp_pulldown_o, 1'b0, dm_pulldown_o, 4'h0};
    assign trc0 = {1'b0, 1'b0, resume_wakeup_enable, 3'h0,
                   sync_ff[1], res_ff[1]};

    // read mux; observe stays read-only since no write path reaches it
    always_comb begin
        next_rdata = 32'h0;
        mapped = 1'b1;
        if (paddr_i == `UTC_OFS_TRANSCEIVER_SUSPEND_PD) begin
            next_rdata[7:0] = {transceiver_suspend_o, weak_pulldown_enable, 6'h0};
        end else if (paddr_i == `UTC_OFS_OBSERVE) begin
            next_rdata[7:0] = obs;
        end else if (paddr_i == `UTC_OFS_PULLUP) begin
            next_rdata[7:0] = {3'h0, device_mode_dplus_pullup, 4'h0};
        end else if (paddr_i == `UTC_OFS_TRC0) begin
            next_rdata[7:0] = trc0;
        end else if (paddr_i == `UTC_OFS_MODE) begin
            next_rdata[1:0] = mode_cfg;
        end else if (paddr_i == `UTC_OFS_IRQ_STAT) begin
            next_rdata[2:0] = irq_stat;
        end else if (paddr_i == `UTC_OFS_IRQ_MASK) begin
            next_rdata[2:0] = irq_mask;
        end else begin
            mapped = 1'b0;
        end
    end

    // apb answer: one wait state, then pready with data and error
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
        end else begin
            pready_o <= rd_take;
            pslverr_o <= rd_take && !mapped;
            if (rd_take && !pwrite_i) begin
                prdata_o <= next_rdata;
            end
        end
    end

    // ==========================================================
    // checks
    transceiver_suspend_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_fire && paddr_i == `UTC_OFS_TRANSCEIVER_SUSPEND_PD && !in_rst
        |=> transceiver_suspend_o == $past(pwdata_i[`UTC_BIT_TRANSCEIVER_SUSPEND]))
        else $error("suspend bit not taken from write");
    pulldown_pair_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ##1 (dp_pulldown_o == $past(weak_pulldown_enable)
        && dm_pulldown_o == dp_pulldown_o))
        else $error("pulldowns do not follow enable");
    reserved_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pready_o && !pwrite_i && $past(paddr_i) == `UTC_OFS_TRANSCEIVER_SUSPEND_PD
        |-> prdata_o[5:0] == 6'h0 && prdata_o[31:8] == 24'h0)
        else $error("reserved bits read nonzero");
    observe_bits_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pready_o && !pwrite_i && paddr_i == `UTC_OFS_OBSERVE && !pslverr_o
        |-> prdata_o[7] == $past(dp_pullup_o) && prdata_o[6] == $past(dp_pulldown_o)
        && prdata_o[4] == $past(dm_pulldown_o) && prdata_o[5] == 1'b0)
        else $error("observe bits wrong");
    pullup_mode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(dp_pullup_o) |-> $past(!host_mode && !otg_mode
        && device_mode_dplus_pullup))
        else $error("pullup enabled outside device mode");
    soft_reset_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_fire && paddr_i == `UTC_OFS_TRC0 && pwdata_i[`UTC_BIT_SOFT_RST]
        |=> module_soft_reset_o [*2] ##1 (!module_soft_reset_o
        && weak_pulldown_enable))
        else $error("soft reset length wrong");
    rst_bit_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pready_o && !pwrite_i && paddr_i == `UTC_OFS_TRC0
        |-> prdata_o[7:6] == 2'h0)
        else $error("soft reset bit reads nonzero");
    wakeup_host_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(wakeup_o) |-> $past(resume_wakeup_enable && !host_mode))
        else $error("wakeup raised in host mode or disabled");
    // read data is captured on the same edge that raises pready, hence depth one
    sync_seen_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pready_o && !pwrite_i && paddr_i == `UTC_OFS_TRC0
        |-> prdata_o[1] == $past(sync_ff[1]))
        else $error("sync seen bit wrong");
    resume_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        resume_int && resume_wakeup_enable |-> ##2 res_ff[1])
        else $error("resume flag not seen in status");
    // output level lags status by nothing, but sees the mask of one edge ago
    irq_level_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ##1 irq_o == |(irq_stat & $past(irq_mask)))
        else $error("interrupt level does not match status and mask");
    wakeup_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !resume_wakeup_enable && $past(!resume_wakeup_enable) |-> !wakeup_o)
        else $error("wakeup pending with resume enable off");
    rst_done_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rst_cnt == 2'h1 |=> irq_stat[`UTC_IRQ_RST_DONE])
        else $error("soft reset done event not recorded");

endmodule : utc_top
`default_nettype wire

// File: utc_host_model.sv
// usb host or hub model: drives the raw D+/D- line levels
`timescale 1ns/1ps
`default_nettype none

module utc_host_model (
    // raw line levels
    output logic dp_o,
    output logic dm_o
);
    // idle J: D+ high, D- low
    initial begin
        dp_o = 1'b1;
        dm_o = 1'b0;
    end

    // resume K state, driven right after a rising edge like every input
    task automatic send_k();
        dp_o <= 1'b0;
        dm_o <= 1'b1;
    endtask : send_k

    // end of resume, back to J
    task automatic send_j();
        dp_o <= 1'b1;
        dm_o <= 1'b0;
    endtask : send_j
endmodule : utc_host_model

`default_nettype wire

// File: tb_usb_transceiver_control.sv
// self-checking bench for the usb transceiver control block
`timescale 1ns/1ps
`default_nettype none
`include "utc_cfg.svh"

module tb_usb_transceiver_control;
    // ==========================================================
    // signals and model state
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] pa = 12'h0;
    logic [31:0] pwd = 32'h0;
    logic sync_int = 1'b0;
    logic [31:0] prd;
    logic prdy, perr, dp, dm, transceiver_suspend, dp_pd, dm_pd, dp_pu, srst, wake, irq;
    logic [31:0] lfsr = 32'h2a2a6754;
    logic [31:0] rdv;
    logic slv;
    int err_total = 0;
    int n_checks = 0;
    int n_soft = 0;
    int m_transceiver_suspend, m_pu, m_mode, m_resen, m_res, m_sync, m_mask, m_stat;
    int m_pde = 1;

    always #5 clk_i = ~clk_i;
    // soft reset width, sampled at edges
    always @(posedge clk_i) if (srst === 1'b1) n_soft++;

    utc_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
        .pslverr_o(perr), .dp_rx_i(dp), .dm_rx_i(dm), .sync_usb_int_i(sync_int),
        .transceiver_suspend_o(transceiver_suspend), .dp_pulldown_o(dp_pd), .dm_pulldown_o(dm_pd),
        .dp_pullup_o(dp_pu), .module_soft_reset_o(srst), .wakeup_o(wake), .irq_o(irq));
    utc_host_model host (.dp_o(dp), .dm_o(dm));

    // ==========================================================
    // helpers
    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : next_rand

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // expected read data from the model state
    function automatic logic [31:0] model_rd(input logic [11:0] a);
        logic pu;
        pu = (m_pu != 0) && (m_mode == 0);
        case (a)
            `UTC_OFS_TRANSCEIVER_SUSPEND_PD: return {24'h0, m_transceiver_suspend[0], m_pde[0], 6'h0};
            `UTC_OFS_OBSERVE: return {24'h0, pu, m_pde[0], 1'b0, m_pde[0], 4'h0};
            `UTC_OFS_PULLUP: return {27'h0, m_pu[0], 4'h0};
            `UTC_OFS_TRC0: return {26'h0, m_resen[0], 3'h0, m_sync[0], m_res[0]};
            `UTC_OFS_MODE: return {30'h0, m_mode[1:0]};
            `UTC_OFS_IRQ_STAT: return {29'h0, m_stat[2:0]};
            `UTC_OFS_IRQ_MASK: return {29'h0, m_mask[2:0]};
            default: return 32'h0;
        endcase
    endfunction : model_rd

    // one apb transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        if (n >= 20) err_total++;
        rdv = prd;
        slv = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        case (a)
            `UTC_OFS_TRANSCEIVER_SUSPEND_PD: {m_transceiver_suspend, m_pde} = {31'h0, d[7], 31'h0, d[6]};
            `UTC_OFS_PULLUP: m_pu = d[4];
            `UTC_OFS_MODE: m_mode = d[1:0];
            `UTC_OFS_IRQ_MASK: m_mask = d[2:0];
            `UTC_OFS_TRC0: begin
                m_resen = d[5];
                if (!d[5]) m_res = 0;
            end
            default: ;
        endcase
        // soft reset returns the control state to reset values
        if (a == `UTC_OFS_TRC0 && d[7]) begin
            {m_transceiver_suspend, m_pu, m_mode, m_resen, m_res} = '0;
            m_pde = 1;
        end
    endtask : wr

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
        chk(rdv, model_rd(a));
        if (a == `UTC_OFS_IRQ_STAT) m_stat = 0;
    endtask : rd

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // watchdog, far beyond the few hundred cycles the tests take
    initial begin
        #200us;
        err_total++;
        tally_and_finish();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk({28'h0, dp_pd, dm_pd, dp_pu, transceiver_suspend}, 32'hc);
        rd(`UTC_OFS_OBSERVE);
        rd(`UTC_OFS_TRC0);
        for (int i = 0; i < 6; i++) begin
            wr(`UTC_OFS_TRANSCEIVER_SUSPEND_PD, next_rand());
            @(posedge clk_i);
            chk({30'h0, transceiver_suspend, dp_pd}, {30'h0, m_transceiver_suspend[0], m_pde[0]});
            chk({31'h0, dm_pd}, m_pde);
            rd(`UTC_OFS_TRANSCEIVER_SUSPEND_PD);
            rd(`UTC_OFS_OBSERVE);
        end
        wr(`UTC_OFS_OBSERVE, 32'hff);
        rd(`UTC_OFS_OBSERVE);
        for (int i = 0; i < 8; i++) begin
            wr(`UTC_OFS_MODE, i % 4);
            wr(`UTC_OFS_PULLUP, (i < 4) ? 32'hff : 32'hef);
            @(posedge clk_i);
            chk({31'h0, dp_pu}, {31'h0, i == 0});
            rd(`UTC_OFS_OBSERVE);
            rd(`UTC_OFS_PULLUP);
        end
        wr(`UTC_OFS_MODE, 32'h0);
        apb(1'b0, 12'h114, 32'h0);
        chk({rdv[30:0], slv}, 32'h1);
        // sync event with its irq masked
        sync_int <= 1'b1;
        m_sync = 1;
        m_stat = 2;
        repeat (5) @(posedge clk_i);
        rd(`UTC_OFS_TRC0);
        sync_int <= 1'b0;
        m_sync = 0;
        repeat (5) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        rd(`UTC_OFS_IRQ_STAT);
        rd(`UTC_OFS_IRQ_STAT);
        // resume wakeup in device mode, irq unmasked
        wr(`UTC_OFS_IRQ_MASK, 32'h1);
        wr(`UTC_OFS_TRC0, 32'h60);
        host.send_k();
        #1 chk({31'h0, wake}, 32'h1);
        m_res = 1;
        m_stat = 1;
        repeat (6) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        rd(`UTC_OFS_TRC0);
        host.send_j();
        wr(`UTC_OFS_TRC0, 32'h40);
        @(posedge clk_i);
        chk({31'h0, wake}, 32'h0);
        rd(`UTC_OFS_IRQ_STAT);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        // host mode: no wakeup
        wr(`UTC_OFS_MODE, 32'h1);
        wr(`UTC_OFS_TRC0, 32'h60);
        host.send_k();
        #1 chk({31'h0, wake}, 32'h0);
        repeat (6) @(posedge clk_i);
        rd(`UTC_OFS_TRC0);
        rd(`UTC_OFS_IRQ_STAT);
        host.send_j();
        // soft reset
        n_soft = 0;
        wr(`UTC_OFS_TRC0, 32'hc0);
        m_stat = 4;
        repeat (3) @(posedge clk_i);
        chk(n_soft, 32'h2);
        rd(`UTC_OFS_TRANSCEIVER_SUSPEND_PD);
        rd(`UTC_OFS_MODE);
        rd(`UTC_OFS_TRC0);
        rd(`UTC_OFS_IRQ_STAT);
        tally_and_finish();
    end
endmodule : tb_usb_transceiver_control

`default_nettype wire
